// ===== scw_config_words.sv
// Configuration word bank with AXI4-Lite access and decoded setup outputs
`timescale 1ns/100ps
`default_nettype none
`include "scw_consts.svh"

module scw_config_words
    import scw_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic shift_enable_o,
    output logic [12:0] shift_pct_o,
    output logic [1:0] converter_gain_o,
    output logic [23:0] limit_one_o,
    output logic [23:0] limit_two_o,
    output logic [6:0] first_amp_gain_o,
    output logic [4:0] second_amp_gain_o,
    output logic chopper_invert_o,
    output logic [4:0] adc_resolution_o,
    output logic misprogram_o
);

    // ==========================================================
    // Functions
    function automatic scw_sel_t sel_of(input logic [7:0] addr);
        scw_sel_t s;
        s = SCW_SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            unique case (addr[7:2])
                `SCW_IDX_SHIFT: s = SCW_SEL_SHIFT;
                `SCW_IDX_LIM1: s = SCW_SEL_LIM1;
                `SCW_IDX_LIM2: s = SCW_SEL_LIM2;
                `SCW_IDX_UPPER: s = SCW_SEL_UPPER;
                `SCW_IDX_SETUP2: s = SCW_SEL_SETUP2;
                `SCW_IDX_STATUS: s = SCW_SEL_STATUS;
                default: s = SCW_SEL_NONE;
            endcase
        end
        return s;
    endfunction

    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [15:0] m;
        m = old;
        if (strb[0]) begin
            m[7:0] = data[7:0];
        end
        if (strb[1]) begin
            m[15:8] = data[15:8];
        end
        return m;
    endfunction

    // Percent in hundredths of a percent
    function automatic logic [12:0] pct_of(input logic [2:0] code);
        logic [12:0] p;
        p = 13'h0000;
        unique case (code)
            3'h0: p = 13'h0000;
            3'h1: p = 13'h02A3;
            3'h2: p = 13'h04E2;
            3'h3: p = 13'h0785;
            3'h4: p = 13'h09C4;
            3'h5: p = 13'h0C67;
            3'h6: p = 13'h0F0A;
            3'h7: p = 13'h10E5;
        endcase
        return p;
    endfunction

    function automatic logic [6:0] amp1_of(input logic [2:0] code);
        logic [6:0] g;
        g = 7'h06;
        unique case (code)
            3'h0: g = 7'h06;
            3'h1: g = 7'h0C;
            3'h2: g = 7'h14;
            3'h3: g = 7'h1E;
            3'h4: g = 7'h28;
            3'h5: g = 7'h3C;
            3'h6: g = 7'h50;
            3'h7: g = 7'h78;
        endcase
        return g;
    endfunction

    // ==========================================================
    // Storage
    logic [15:0] shift_word_reg;
    logic [15:0] lim1_word_reg;
    logic [15:0] lim2_word_reg;
    logic [15:0] upper_word_reg;
    logic [15:0] setup2_word_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // ==========================================================
    // Write channel
    wire aw_take = s_axi_awvalid_i & awready_reg;
    wire w_take = s_axi_wvalid_i & wready_reg;
    wire wr_go = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    wire scw_sel_t wr_sel = sel_of(aw_addr_reg);
    wire aw_hold_next = aw_take | (aw_hold_reg & ~wr_go);
    wire w_hold_next = w_take | (w_hold_reg & ~wr_go);
    wire bvalid_next = wr_go | (bvalid_reg & ~s_axi_bready_i);
    wire awready_next = ~aw_hold_next & ~bvalid_next;
    wire wready_next = ~w_hold_next & ~bvalid_next;
    wire [7:0] aw_addr_next = aw_take ? s_axi_awaddr_i : aw_addr_reg;
    wire [31:0] w_data_next = w_take ? s_axi_wdata_i : w_data_reg;
    wire [3:0] w_strb_next = w_take ? s_axi_wstrb_i : w_strb_reg;
    wire [1:0] bresp_next = !wr_go ? bresp_reg :
        (wr_sel == SCW_SEL_NONE) ? `SCW_RESP_SLVERR : `SCW_RESP_OKAY;

    wire [15:0] shift_word_next = (wr_go && wr_sel == SCW_SEL_SHIFT) ?
        merge16(shift_word_reg, w_data_reg, w_strb_reg) : shift_word_reg;
    wire [15:0] lim1_word_next = (wr_go && wr_sel == SCW_SEL_LIM1) ?
        merge16(lim1_word_reg, w_data_reg, w_strb_reg) : lim1_word_reg;
    wire [15:0] lim2_word_next = (wr_go && wr_sel == SCW_SEL_LIM2) ?
        merge16(lim2_word_reg, w_data_reg, w_strb_reg) : lim2_word_reg;
    wire [15:0] upper_word_next = (wr_go && wr_sel == SCW_SEL_UPPER) ?
        merge16(upper_word_reg, w_data_reg, w_strb_reg) : upper_word_reg;
    // Bits 15:11 are stored as written so the host can preserve them
    wire [15:0] setup2_word_next = (wr_go && wr_sel == SCW_SEL_SETUP2) ?
        merge16(setup2_word_reg, w_data_reg, w_strb_reg) : setup2_word_reg;

    // ==========================================================
    // Decoding
    wire sel_bit = shift_word_reg[`SCW_SEL_BIT];
    wire [2:0] pct_code = shift_word_reg[`SCW_PCT_HI:`SCW_PCT_LO];
    wire [2:0] g1_code = setup2_word_reg[`SCW_G1_HI:`SCW_G1_LO];
    wire [2:0] g2_code = setup2_word_reg[`SCW_G2_HI:`SCW_G2_LO];
    wire [3:0] res_code = setup2_word_reg[`SCW_RES_HI:`SCW_RES_LO];
    wire res_bad = res_code > `SCW_RES_MAX_CODE;
    wire pct_bad = ~sel_bit & (pct_code != 3'h0);
    wire [12:0] pct_next = sel_bit ? pct_of(pct_code) : 13'h0000;
    wire [1:0] gain_next = sel_bit ? `SCW_GAIN_TWO : `SCW_GAIN_ONE;
    wire [23:0] lim1_next = {upper_word_reg[`SCW_UP1_HI:`SCW_UP1_LO], lim1_word_reg};
    wire [23:0] lim2_next = {upper_word_reg[`SCW_UP2_HI:`SCW_UP2_LO], lim2_word_reg};
    wire [6:0] amp1_next = amp1_of(g1_code);
    wire [4:0] amp2_next = `SCW_G2_BASE + {2'h0, g2_code};
    wire chop_next = setup2_word_reg[`SCW_POL_BIT];
    // Unused resolution codes keep the last valid resolution
    wire [4:0] res_next = res_bad ? adc_resolution_o : `SCW_RES_BASE + {1'b0, res_code};
    wire [15:0] status_word = {14'h0000, res_bad, pct_bad};

    // ==========================================================
    // Read channel
    wire ar_take = s_axi_arvalid_i & arready_reg;
    wire scw_sel_t rd_sel = sel_of(s_axi_araddr_i);
    wire rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready_i);
    wire arready_next = ~rvalid_next;
    wire [15:0] rd_word =
        (rd_sel == SCW_SEL_SHIFT) ? shift_word_reg :
        (rd_sel == SCW_SEL_LIM1) ? lim1_word_reg :
        (rd_sel == SCW_SEL_LIM2) ? lim2_word_reg :
        (rd_sel == SCW_SEL_UPPER) ? upper_word_reg :
        (rd_sel == SCW_SEL_SETUP2) ? setup2_word_reg :
        (rd_sel == SCW_SEL_STATUS) ? status_word : 16'h0000;
    wire [31:0] rdata_next = ar_take ? {16'h0000, rd_word} : rdata_reg;
    wire [1:0] rresp_next = !ar_take ? rresp_reg :
        (rd_sel == SCW_SEL_NONE) ? `SCW_RESP_SLVERR : `SCW_RESP_OKAY;

    // ==========================================================
    // Flip-flops
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            shift_word_reg <= `SCW_RST_WORD;
            lim1_word_reg <= `SCW_RST_WORD;
            lim2_word_reg <= `SCW_RST_WORD;
            upper_word_reg <= `SCW_RST_WORD;
            setup2_word_reg <= `SCW_RST_WORD;
        end else begin
            shift_word_reg <= shift_word_next;
            lim1_word_reg <= lim1_word_next;
            lim2_word_reg <= lim2_word_next;
            upper_word_reg <= upper_word_next;
            setup2_word_reg <= setup2_word_next;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `SCW_RESP_OKAY;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            aw_addr_reg <= aw_addr_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `SCW_RESP_OKAY;
        end else begin
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            shift_enable_o <= 1'b0;
            shift_pct_o <= 13'h0000;
            converter_gain_o <= `SCW_GAIN_ONE;
            limit_one_o <= 24'h00_0000;
            limit_two_o <= 24'h00_0000;
            first_amp_gain_o <= 7'h06;
            second_amp_gain_o <= `SCW_G2_BASE;
            chopper_invert_o <= 1'b0;
            adc_resolution_o <= `SCW_RES_BASE;
            misprogram_o <= 1'b0;
        end else begin
            shift_enable_o <= sel_bit;
            shift_pct_o <= pct_next;
            converter_gain_o <= gain_next;
            limit_one_o <= lim1_next;
            limit_two_o <= lim2_next;
            first_amp_gain_o <= amp1_next;
            second_amp_gain_o <= amp2_next;
            chopper_invert_o <= chop_next;
            adc_resolution_o <= res_next;
            misprogram_o <= pct_bad | res_bad;
        end
    end

    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o = wready_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_pct_decode: assert property (
        !$past(rst_i) && $past(sel_bit) && $past(pct_code) == 3'h7 |-> shift_pct_o == 13'h10E5)
        else $error("shift percent code 7 not decoded");
    a_shift_gate: assert property (
        !$past(rst_i) |-> shift_enable_o == $past(shift_word_reg[`SCW_SEL_BIT]))
        else $error("shift enable does not follow select bit");
    a_no_shift_off: assert property (
        !shift_enable_o |-> shift_pct_o == 13'h0000 && converter_gain_o == `SCW_GAIN_ONE)
        else $error("shift or gain active while select is off");
    a_gain_two_on: assert property (
        shift_enable_o |-> converter_gain_o == `SCW_GAIN_TWO)
        else $error("converter gain not two with shift on");
    a_limit_one: assert property (
        !$past(rst_i) |-> limit_one_o == {$past(upper_word_reg[7:0]), $past(lim1_word_reg)})
        else $error("limit one assembled wrong");
    a_limit_two: assert property (
        !$past(rst_i) |-> limit_two_o == {$past(upper_word_reg[15:8]), $past(lim2_word_reg)})
        else $error("limit two assembled wrong");
    a_amp1_top: assert property (
        !$past(rst_i) && $past(g1_code) == 3'h7 |-> first_amp_gain_o == 7'h78)
        else $error("first amplifier top gain wrong");
    a_amp2_step: assert property (
        !$past(rst_i) |-> second_amp_gain_o == 5'h0B + {2'h0, $past(g2_code)})
        else $error("second amplifier gain wrong");
    a_chop_polarity: assert property (
        $rose(setup2_word_reg[`SCW_POL_BIT]) |=> chopper_invert_o)
        else $error("chopper not inverted");
    a_res_range: assert property (
        adc_resolution_o >= 5'h0C && adc_resolution_o <= 5'h18)
        else $error("resolution out of range");
    a_bvalid_hold: assert property (
        bvalid_reg && !s_axi_bready_i |=> bvalid_reg && $stable(bresp_reg))
        else $error("write response dropped");

endmodule

`default_nettype wire

// ===== scw_consts.svh
// Offsets, field positions, reset values and codes of the configuration word bank
`ifndef SCW_CONSTS_SVH
`define SCW_CONSTS_SVH

// Register indices; byte address is four times the index
`define SCW_IDX_SHIFT 6'h12
`define SCW_IDX_LIM1 6'h13
`define SCW_IDX_LIM2 6'h14
`define SCW_IDX_UPPER 6'h15
`define SCW_IDX_SETUP2 6'h16
`define SCW_IDX_STATUS 6'h18

// Field positions
`define SCW_SEL_BIT 15
`define SCW_PCT_HI 14
`define SCW_PCT_LO 12
`define SCW_G1_HI 2
`define SCW_G1_LO 0
`define SCW_G2_HI 5
`define SCW_G2_LO 3
`define SCW_POL_BIT 6
`define SCW_RES_HI 10
`define SCW_RES_LO 7
`define SCW_UP1_HI 7
`define SCW_UP1_LO 0
`define SCW_UP2_HI 15
`define SCW_UP2_LO 8

// Reset values and codes
`define SCW_RST_WORD 16'h0000
`define SCW_RES_MAX_CODE 4'hC
`define SCW_RES_BASE 5'h0C
`define SCW_G2_BASE 5'h0B
`define SCW_GAIN_ONE 2'h1
`define SCW_GAIN_TWO 2'h2
`define SCW_RESP_OKAY 2'h0
`define SCW_RESP_SLVERR 2'h2

`endif

// ===== scw_pkg.sv
// Types shared by the configuration word bank
`default_nettype none
package scw_pkg;
    typedef enum logic [2:0] {
        SCW_SEL_SHIFT,
        SCW_SEL_LIM1,
        SCW_SEL_LIM2,
        SCW_SEL_UPPER,
        SCW_SEL_SETUP2,
        SCW_SEL_STATUS,
        SCW_SEL_NONE
    } scw_sel_t;
endpackage

`default_nettype wire

// ===== test_scw_config_words.sv
// Self-checking testbench of the configuration word bank
`timescale 1ns/100ps
`default_nettype none
`include "scw_consts.svh"

module test_scw_config_words;
    // ==========================================================
    // Signals and design
    logic sys_clk = 1'b0, rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, enable, chop, misprog;
    logic [1:0] bresp, rresp, cgain;
    logic [12:0] pct;
    logic [23:0] lim1, lim2;
    logic [6:0] g1;
    logic [4:0] g2, res;
    int mismatches = 0, compares = 0;
    logic [31:0] d;
    logic [15:0] a, b, u, w;
    logic [4:0] hi;
    logic [1:0] r;

    scw_config_words dut (.sys_clk_i(sys_clk), .rst_i(rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .shift_enable_o(enable),
        .shift_pct_o(pct), .converter_gain_o(cgain), .limit_one_o(lim1), .limit_two_o(lim2),
        .first_amp_gain_o(g1), .second_amp_gain_o(g2), .chopper_invert_o(chop), .adc_resolution_o(res),
        .misprogram_o(misprog));

    always #12.5 sys_clk = ~sys_clk;

    // ==========================================================
    // Expectations and bus tasks
    function automatic logic [12:0] pct_exp(input logic [2:0] c);
        logic [12:0] t [8];
        t = '{13'h0000, 13'h02a3, 13'h04e2, 13'h0785, 13'h09c4, 13'h0c67, 13'h0f0a, 13'h10e5};
        return t[c];
    endfunction

    function automatic logic [6:0] g1_exp(input logic [2:0] c);
        logic [6:0] t [8];
        t = '{7'h06, 7'h0c, 7'h14, 7'h1e, 7'h28, 7'h3c, 7'h50, 7'h78};
        return t[c];
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic axi_write(input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] st, output logic [1:0] rs);
        bit aw_done, w_done, b_done, late;
        aw_done = 0;
        w_done = 0;
        b_done = 0;
        late = 1'($urandom);
        rs = 2'h3;
        @(posedge sys_clk);
        awaddr <= ad;
        wdata <= dt;
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= ~late;
        while (!b_done) begin
            @(posedge sys_clk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1;
                wvalid <= 1'b0;
            end
            if (bvalid === 1'b1 && bready === 1'b1) begin
                b_done = 1;
                rs = bresp;
                bready <= 1'b0;
            end else if (bvalid === 1'b1) begin
                // Late ready makes the response wait at least one cycle
                bready <= 1'b1;
            end
        end
        @(posedge sys_clk);
        #1;
    endtask

    task automatic axi_read(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
        bit ar_done, r_done;
        ar_done = 0;
        r_done = 0;
        rs = 2'h3;
        dt = 32'hdead_beef;
        @(posedge sys_clk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_done) begin
            @(posedge sys_clk);
            if (!ar_done && arready === 1'b1) begin
                ar_done = 1;
                arvalid <= 1'b0;
            end
            if (rvalid === 1'b1) begin
                r_done = 1;
                dt = rdata;
                rs = rresp;
                rready <= 1'b0;
            end
        end
    endtask

    // Write one word with both lanes and compare its read-back
    task automatic put(input logic [5:0] idx, input logic [15:0] v);
        axi_write({idx, 2'b00}, {16'($urandom), v}, 4'h3, r);
        check(r, `SCW_RESP_OKAY);
        axi_read({idx, 2'b00}, d, r);
        check(d, {16'h0000, v});
        check(r, `SCW_RESP_OKAY);
    endtask

    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        mismatches++;
        print_verdict;
    end

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'h93eb019c));
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        check({enable, cgain, pct, misprog}, {1'b0, `SCW_GAIN_ONE, 13'h0000, 1'b0});
        check(lim1, 24'h00_0000);
        check(lim2, 24'h00_0000);
        check({g1, g2, chop, res}, {7'h06, 5'h0b, 1'b0, 5'h0c});
        for (int i = 'h12; i <= 'h16; i++) begin
            axi_read({i[5:0], 2'b00}, d, r);
            check(d, 32'h0000_0000);
        end
        for (int c = 0; c < 8; c++) begin
            put(`SCW_IDX_SHIFT, {1'b1, c[2:0], 12'($urandom)});
            check({enable, cgain, pct}, {1'b1, `SCW_GAIN_TWO, pct_exp(c[2:0])});
        end
        put(`SCW_IDX_SHIFT, {4'h0, 12'($urandom)});
        check({enable, cgain, pct, misprog}, {1'b0, `SCW_GAIN_ONE, 13'h0000, 1'b0});
        put(`SCW_IDX_SHIFT, 16'h5000);
        check({enable, pct, misprog}, {1'b0, 13'h0000, 1'b1});
        axi_read({`SCW_IDX_STATUS, 2'b00}, d, r);
        check(d, 32'h0000_0001);
        put(`SCW_IDX_SHIFT, 16'h0000);
        repeat (4) begin
            a = 16'($urandom);
            b = 16'($urandom);
            u = 16'($urandom);
            put(`SCW_IDX_LIM1, a);
            put(`SCW_IDX_LIM2, b);
            put(`SCW_IDX_UPPER, u);
            check(lim1, {u[7:0], a});
            check(lim2, {u[15:8], b});
        end
        axi_write({`SCW_IDX_UPPER, 2'b00}, 32'h0000_a55a, 4'h1, r);
        check(r, `SCW_RESP_OKAY);
        check(lim1, {8'h5a, a});
        check(lim2, {u[15:8], b});
        hi = 5'($urandom);
        for (int i = 0; i < 13; i++) begin
            w = {hi, i[3:0], i[0], i[2:0], 3'(i + 3)};
            put(`SCW_IDX_SETUP2, w);
            check(g1, g1_exp(w[2:0]));
            check(g2, 5'h0b + w[5:3]);
            check(chop, w[6]);
            check({res, misprog}, {5'h0c + i[4:0], 1'b0});
        end
        for (int i = 13; i < 16; i++) begin
            put(`SCW_IDX_SETUP2, {hi, i[3:0], 7'h00});
            check({res, misprog}, {5'h18, 1'b1});
        end
        axi_read({`SCW_IDX_STATUS, 2'b00}, d, r);
        check(d, 32'h0000_0002);
        axi_write(8'h00, 32'h0000_ffff, 4'h3, r);
        check(r, `SCW_RESP_SLVERR);
        axi_read(8'h49, d, r);
        check(d, 32'h0000_0000);
        check(r, `SCW_RESP_SLVERR);
        // Second reset in mid-run returns the decoded outputs to their idle values
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        check({lim1, res, misprog}, {24'h00_0000, 5'h0c, 1'b0});
        axi_write({`SCW_IDX_STATUS, 2'b00}, 32'h0000_0000, 4'h3, r);
        check(r, `SCW_RESP_OKAY);
        print_verdict;
    end
endmodule

`default_nettype wire
